// *** core/serial_port_pkg.sv ***
package serial_port_pkg;

  // ****************************************************************
  // Register map of the AXI4-Lite slave
  // ****************************************************************
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] RESA_OFFSET   = 8'h08;
  localparam logic [7:0] RESB_OFFSET   = 8'h0C;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int CTRL_CLK_SRC_BIT    = 0;
  localparam int CTRL_RD_TIMING_BIT  = 1;
  localparam int CTRL_CLK_INV_BIT    = 2;
  localparam int CTRL_STB_INV_BIT    = 3;
  localparam int CTRL_ORDER_BIT      = 4;
  localparam int CTRL_DIV_LSB        = 5;
  localparam int CTRL_SERIAL_BIT     = 7;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0090;

  // ****************************************************************
  // Status register fields
  // ****************************************************************
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_EOC_BIT    = 1;
  localparam int STAT_LATE_BIT   = 2;
  localparam int STAT_ACTIVE_BIT = 3;

  // ****************************************************************
  // Timing counts
  // ****************************************************************
  localparam int WORD_BITS      = 32;
  localparam int CHAN_BITS      = 16;
  localparam int SCLK_HALF_BASE = 2;
  localparam int LSB_STRETCH    = 2;

  // Master shifter states.
  typedef enum logic [1:0] {
    M_IDLE,
    M_LOW,
    M_HIGH,
    M_DONE
  } master_state_e;

endpackage

// *** core/pin_sync.sv ***
`timescale 1ns/100ps

module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  // Pins.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // Two stages; the first is read by the second only.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// *** core/axil_regs.sv ***
`timescale 1ns/100ps

module axil_regs (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // AXI4-Lite write channels.
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Block side.
  output logic [31:0]      ctrl,
  input  wire logic [31:0] status,
  input  wire logic [15:0] res_a,
  input  wire logic [15:0] res_b
);

  typedef struct packed {
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [31:0] ctrl;
  } regs_s;

  regs_s st_r;
  regs_s st_nxt;

  // Ready while a slot is empty; one write and one read at a time.
  assign awready = !st_r.aw_have && !st_r.bvalid;
  assign wready  = !st_r.w_have && !st_r.bvalid;
  assign arready = !st_r.rvalid;
  assign bvalid  = st_r.bvalid;
  assign bresp   = st_r.bresp;
  assign rvalid  = st_r.rvalid;
  assign rdata   = st_r.rdata;
  assign rresp   = st_r.rresp;
  assign ctrl    = st_r.ctrl;

  // Address and data are taken in either order; the write lands with both.
  always_comb begin
    st_nxt = st_r;
    if (awvalid && awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.w_data = wdata;
      st_nxt.w_strb = wstrb;
    end
    if (st_r.aw_have && st_r.w_have) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = 2'h0;
      if (st_r.aw_addr[7:2] == serial_port_pkg::CTRL_OFFSET[7:2]) begin
        for (int i = 0; i < 4; i++) begin
          if (st_r.w_strb[i]) begin
            st_nxt.ctrl[i*8 +: 8] = st_r.w_data[i*8 +: 8];
          end
        end
      end else if (st_r.aw_addr[7:2] != serial_port_pkg::STATUS_OFFSET[7:2] &&
                   st_r.aw_addr[7:2] != serial_port_pkg::RESA_OFFSET[7:2] &&
                   st_r.aw_addr[7:2] != serial_port_pkg::RESB_OFFSET[7:2]) begin
        st_nxt.bresp = 2'h2;
      end
    end
    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = 2'h0;
      case (araddr[7:2])
        serial_port_pkg::CTRL_OFFSET[7:2]:   st_nxt.rdata = st_r.ctrl;
        serial_port_pkg::STATUS_OFFSET[7:2]: st_nxt.rdata = status;
        serial_port_pkg::RESA_OFFSET[7:2]:   st_nxt.rdata = {16'h0000, res_a};
        serial_port_pkg::RESB_OFFSET[7:2]:   st_nxt.rdata = {16'h0000, res_b};
        default: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = 2'h2;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r      <= '0;
      st_r.ctrl <= serial_port_pkg::CTRL_RESET;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

endmodule

// *** core/adc_serial_result_port.sv ***
`timescale 1ns/100ps


module adc_serial_result_port #(
  parameter int HALF_BASE = serial_port_pkg::SCLK_HALF_BASE
) (
  // Clock, enable and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // AXI4-Lite register bus.
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Conversion engine, same clock.
  input  wire logic        conv_busy,
  input  wire logic        conv_eoc_n,
  input  wire logic        result_valid,
  input  wire logic [15:0] result_a,
  input  wire logic [15:0] result_b,
  // Serial pins.
  input  wire logic        chip_select_n,
  input  wire logic        read_enable_n,
  input  wire logic        read_timing_select_chain_input,
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe,
  output logic             serial_data_out,
  output logic             serial_data_out_oe,
  output logic             valid_strobe,
  output logic             strobe_oe,
  output logic             busy,
  output logic             late_read_error
);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  initial begin
    // The slowest divider shifts the base left by three into an 8-bit count.
    if (HALF_BASE < 1 || HALF_BASE > 31) begin
      $error("HALF_BASE out of range");
    end
  end

  // ****************************************************************
  // Pin synchronisers and registers
  // ****************************************************************
  logic [3:0]  pins_s;
  logic [31:0] ctrl;
  logic [31:0] status;

  pin_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .ce       (ce),
    .async_in ({chip_select_n, read_enable_n, read_timing_select_chain_input, sclk_in}),
    .sync_out (pins_s)
  );

  logic cs_n_s;
  logic rd_n_s;
  logic chain_s;
  logic sclk_s;
  assign cs_n_s  = pins_s[3];
  assign rd_n_s  = pins_s[2];
  assign chain_s = pins_s[1];
  assign sclk_s  = pins_s[0];

  typedef struct packed {
    logic                          sclk_q;
    logic [31:0]                   shreg;
    logic [31:0]                   prev;
    logic [5:0]                    bit_cnt;
    logic [7:0]                    div_cnt;
    serial_port_pkg::master_state_e mstate;
    logic                          mclk;
    logic                          mstb;
    logic                          hold_busy;
    logic                          word_ready;
    logic                          late;
    logic                          during;
    logic                          sdo;
    logic [15:0]                   cap_a;
    logic [15:0]                   cap_b;
    logic                          was_busy;
  } port_s;

  port_s st_r;
  port_s st_nxt;

  axil_regs u_regs (
    .clk     (clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .ctrl    (ctrl),
    .status  (status),
    .res_a   (st_r.cap_a),
    .res_b   (st_r.cap_b)
  );

  // ****************************************************************
  // Control decode
  // ****************************************************************
  logic       slave_mode;
  logic       clk_inv;
  logic       stb_inv;
  logic       a_first;
  logic [1:0] divider;
  logic       serial_on;
  logic       during_sel;
  logic       enabled;

  assign slave_mode = ctrl[serial_port_pkg::CTRL_CLK_SRC_BIT];
  assign clk_inv    = ctrl[serial_port_pkg::CTRL_CLK_INV_BIT];
  assign stb_inv    = ctrl[serial_port_pkg::CTRL_STB_INV_BIT];
  assign a_first    = ctrl[serial_port_pkg::CTRL_ORDER_BIT];
  assign divider    = ctrl[serial_port_pkg::CTRL_DIV_LSB +: 2];
  assign serial_on  = ctrl[serial_port_pkg::CTRL_SERIAL_BIT];
  // The pin doubles as chain input, so it selects timing only in master mode.
  assign during_sel = slave_mode ? ctrl[serial_port_pkg::CTRL_RD_TIMING_BIT]
                                 : chain_s;
  assign enabled    = serial_on && !cs_n_s && !rd_n_s;

  // Half period of the master clock: divider in read-after-convert,
  // conversion-locked base with a stretch on the LSBs during conversion.
  logic [7:0] half_len;
  always_comb begin
    if (!st_r.during) begin
      half_len = 8'(HALF_BASE << divider);
    end else if (st_r.bit_cnt == 6'd15 || st_r.bit_cnt == 6'd31) begin
      half_len = 8'(HALF_BASE + serial_port_pkg::LSB_STRETCH);
    end else begin
      half_len = 8'(HALF_BASE);
    end
  end

  // Both edges of the host clock seen after synchronising. The clock must idle
  // low, since each fall shifts and the word MSB is taken on the first rise.
  logic s_rise;
  logic s_fall;
  assign s_rise = sclk_s && !st_r.sclk_q;
  assign s_fall = !sclk_s && st_r.sclk_q;

  logic conv_end;
  assign conv_end = st_r.was_busy && !conv_busy;

  // ****************************************************************
  // Shifter and mode sequencing
  // ****************************************************************
  always_comb begin
    st_nxt          = st_r;
    st_nxt.sclk_q   = sclk_s;
    st_nxt.was_busy = conv_busy;

    // New result: hold the word ordered by the channel select.
    if (result_valid) begin
      st_nxt.cap_a = result_a;
      st_nxt.cap_b = result_b;
      st_nxt.prev  = a_first ? {result_a, result_b}
                             : {result_b, result_a};
      st_nxt.word_ready = 1'b1;
    end

    // Late read: the old word was not fully clocked before the end.
    st_nxt.late = 1'b0;
    if (slave_mode && during_sel && conv_end &&
        st_r.bit_cnt != 6'd0 && st_r.bit_cnt < 6'(serial_port_pkg::WORD_BITS)) begin
      st_nxt.late = 1'b1;
    end

    if (slave_mode) begin
      st_nxt.mstate    = serial_port_pkg::M_IDLE;
      st_nxt.mclk      = 1'b0;
      st_nxt.mstb      = 1'b0;
      st_nxt.hold_busy = 1'b0;
      if (!enabled) begin
        st_nxt.bit_cnt = 6'd0;
      end else begin
        // Load at the start of a read window.
        if (st_r.bit_cnt == 6'd0 && !s_rise && !s_fall) begin
          st_nxt.shreg = during_sel ? st_r.prev
                                    : (a_first ? {st_r.cap_a, st_r.cap_b}
                                               : {st_r.cap_b, st_r.cap_a});
          st_nxt.sdo   = st_nxt.shreg[31];
        end
        if (s_fall) begin
          // Shift on the falling edge; in read-after-convert the chain bit fills the vacated slot on the next rise.
          st_nxt.sdo     = st_r.shreg[30];
          st_nxt.shreg   = {st_r.shreg[30:0], 1'b0};
          st_nxt.bit_cnt = 6'(st_r.bit_cnt + 6'd1);
        end
        // The first rise comes before any shift, so the word LSB must not be overwritten.
        if (s_rise && !during_sel && st_r.bit_cnt != 6'd0) begin
          st_nxt.shreg[0] = chain_s;
        end
      end
    end else begin
      case (st_r.mstate)
        serial_port_pkg::M_IDLE: begin
          st_nxt.mclk = 1'b0;
          st_nxt.mstb = 1'b0;
          if (serial_on && (during_sel ? conv_busy && st_r.word_ready
                                       : result_valid)) begin
            st_nxt.during    = during_sel;
            st_nxt.shreg     = during_sel ? st_r.prev : st_nxt.prev;
            st_nxt.sdo       = st_nxt.shreg[31];
            st_nxt.bit_cnt   = 6'd0;
            st_nxt.div_cnt   = 8'd0;
            st_nxt.mstb      = 1'b1;
            st_nxt.hold_busy = !during_sel;
            st_nxt.mstate    = serial_port_pkg::M_LOW;
          end
        end
        serial_port_pkg::M_LOW: begin
          st_nxt.div_cnt = 8'(st_r.div_cnt + 8'd1);
          if (st_r.div_cnt + 8'd1 >= half_len) begin
            st_nxt.div_cnt = 8'd0;
            st_nxt.mclk    = 1'b1;
            st_nxt.mstate  = serial_port_pkg::M_HIGH;
          end
        end
        serial_port_pkg::M_HIGH: begin
          st_nxt.div_cnt = 8'(st_r.div_cnt + 8'd1);
          if (st_r.div_cnt + 8'd1 >= half_len) begin
            // Data changes with the falling edge, so it stands for a whole period around the rise.
            st_nxt.div_cnt = 8'd0;
            st_nxt.mclk    = 1'b0;
            st_nxt.shreg   = {st_r.shreg[30:0], 1'b0};
            st_nxt.sdo     = st_r.shreg[30];
            st_nxt.bit_cnt = 6'(st_r.bit_cnt + 6'd1);
            if (st_r.during && (st_r.bit_cnt == 6'd15)) begin
              st_nxt.mstb = 1'b0;
            end else if (st_r.during && st_r.bit_cnt == 6'd16) begin
              st_nxt.mstb = 1'b1;
            end
            if (st_r.bit_cnt == 6'(serial_port_pkg::WORD_BITS - 1)) begin
              st_nxt.mstb       = 1'b0;
              st_nxt.hold_busy  = 1'b0;
              st_nxt.word_ready = 1'b0;
              st_nxt.mstate     = serial_port_pkg::M_DONE;
            end else begin
              st_nxt.mstate = serial_port_pkg::M_LOW;
            end
          end
        end
        serial_port_pkg::M_DONE: begin
          if (!conv_busy) begin
            st_nxt.mstate = serial_port_pkg::M_IDLE;
          end
        end
        default: begin
          st_nxt.mstate = serial_port_pkg::M_IDLE;
        end
      endcase
    end
  end

  // State register; clock enable freezes everything.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  assign serial_data_out = st_r.sdo;
  assign serial_data_out_oe        = enabled;
  assign sclk_out        = st_r.mclk ^ clk_inv;
  assign sclk_oe         = enabled && !slave_mode;
  assign valid_strobe    = st_r.mstb ^ stb_inv;
  assign strobe_oe       = enabled && !slave_mode;
  assign busy            = conv_busy || st_r.hold_busy;
  assign late_read_error = st_r.late;

  assign status = {28'h0000000,
                   st_r.mstate != serial_port_pkg::M_IDLE,
                   st_r.late,
                   conv_eoc_n,
                   busy};

endmodule

// *** tb/adc_serial_result_port_monitor.sv ***
`timescale 1ns/100ps
// ******
// Port checker
// ******
module adc_serial_result_port_monitor (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       rst_b,
  // Register bus.
  input wire logic [7:0] araddr,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic [1:0] rresp,
  input wire logic       rvalid,
  // Conversion and pins.
  input wire logic       conv_busy,
  input wire logic       result_valid,
  input wire logic       chip_select_n,
  input wire logic       read_enable_n,
  input wire logic       sclk_oe,
  input wire logic       serial_data_out_oe,
  input wire logic       valid_strobe,
  input wire logic       strobe_oe,
  input wire logic       busy,
  input wire logic       late_read_error
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Enables lag the pin synchronizers, so five samples are allowed.
  a_cs_hiz: assert property (chip_select_n [*5] |-> !serial_data_out_oe)
    else $error("data enabled while deselected");
  a_rd_hiz: assert property (read_enable_n [*5] |-> !serial_data_out_oe)
    else $error("data enabled while read is off");
  a_strobe_oe: assert property (strobe_oe == sclk_oe)
    else $error("strobe and clock enables differ");
  a_busy_conv: assert property (conv_busy |-> ##[0:1] busy)
    else $error("busy low during conversion");
  a_late_once: assert property (late_read_error |=> !late_read_error)
    else $error("late read error too long");
  a_late_slave: assert property (late_read_error |-> !conv_busy && !sclk_oe)
    else $error("late read error outside a slave conversion end");
  a_ar_block: assert property (rvalid |-> !arready)
    else $error("read address taken while answer pending");
  a_bad_addr: assert property (arvalid && arready && araddr > 8'h0C |=> rvalid && rresp == 2'h2)
    else $error("unmapped read not refused");
  // Main scenarios reached.
  c_master: cover property (result_valid ##[1:40] valid_strobe);
  c_late: cover property (late_read_error);
  c_slave: cover property (serial_data_out_oe && !sclk_oe);
endmodule

bind adc_serial_result_port adc_serial_result_port_monitor mon (
  .clk, .rst_b, .araddr, .arvalid, .arready, .rresp, .rvalid, .conv_busy, .result_valid,
  .chip_select_n, .read_enable_n, .sclk_oe, .serial_data_out_oe, .valid_strobe, .strobe_oe, .busy,
  .late_read_error
);

// *** tb/host_serial_model.sv ***
`timescale 1ns/100ps
// ******
// Host serial port
// ******
module host_serial_model (
  // Bench clock and device outputs.
  input  wire logic clk,
  input  wire logic sclk_out,
  input  wire logic serial_data_out,
  input  wire logic valid_strobe,
  input  wire logic busy,
  // Host pins.
  output logic      sclk_in,
  output logic      chip_select_n,
  output logic      read_enable_n,
  output logic      read_timing_select_chain_input
);
  // The gated clock idles low and toggles only inside a frame.
  initial begin
    sclk_in = 1'b0;
    sel(1'b1, 1'b1);
  end
  // Selects move together; the chain pin is set to the given level.
  task automatic sel(input logic off, input logic lvl);
    chip_select_n = off;
    read_enable_n = off;
    read_timing_select_chain_input = lvl;
  endtask
  // Slave frame at 160 ns; bits are taken mid-high, long after the synced shift.
  task automatic slave_read(input int n, output logic [63:0] w);
    w = '0;
    sel(1'b0, read_timing_select_chain_input);
    #205;
    for (int i = 0; i < n; i++) begin
      sclk_in = 1'b1;
      #40;
      w = {w[62:0], serial_data_out};
      #40;
      sclk_in = 1'b0;
      #80;
    end
    sel(1'b1, read_timing_select_chain_input);
  endtask
  // Master frame: bits are taken as the true clock rises, whatever the inversion.
  task automatic master_read(input logic inv, output logic [31:0] w, output int per,
                             output logic stb, output logic bsy);
    int   n;
    int   t0;
    logic p;
    n = 0;
    t0 = 0;
    per = 0;
    w = '0;
    p = sclk_out;
    for (int c = 0; c < 4000 && n < 32; c++) begin
      @(posedge clk);
      if (sclk_out !== p && sclk_out === ~inv) begin
        if (n == 0) {stb, bsy} = {valid_strobe, busy};
        if (n == 1) per = c - t0;
        // This bit ends set only when the strobe differs between the first bit and bit 16, as it does when it moves between the two channels.
        if (n == 16) stb ^= valid_strobe;
        w = {w[30:0], serial_data_out};
        t0 = c;
        n++;
      end
      p = sclk_out;
    end
  endtask
endmodule

// *** tb/adc_serial_result_port_tb_top.sv ***
`timescale 1ns/100ps
// ******
// Bench
// ******
module adc_serial_result_port_tb_top;
  logic        clk, rst_b, ce, awvalid, awready, wvalid, wready, bvalid, bready, arvalid;
  logic        arready, rvalid, rready, conv_busy, conv_eoc_n, result_valid, s, b;
  logic        chip_select_n, read_enable_n, read_timing_select_chain_input, sclk_in;
  logic        sclk_out, sclk_oe, serial_data_out, serial_data_out_oe, valid_strobe, strobe_oe;
  logic        busy, late_read_error;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, w;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] result_a, result_b;
  logic [63:0] sw;
  logic [31:0] exp_q[$];
  int          fail_count, samples_checked, per;

  adc_serial_result_port #(.HALF_BASE(2)) dut (
    .clk, .rst_b, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .conv_busy, .conv_eoc_n, .result_valid, .result_a, .result_b,
    .chip_select_n, .read_enable_n, .read_timing_select_chain_input, .sclk_in,
    .sclk_out, .sclk_oe, .serial_data_out, .serial_data_out_oe, .valid_strobe, .strobe_oe,
    .busy, .late_read_error
  );
  host_serial_model host (
    .clk, .sclk_out, .serial_data_out, .valid_strobe, .busy, .sclk_in, .chip_select_n,
    .read_enable_n, .read_timing_select_chain_input
  );

  // 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Verdict and run end.
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One comparison.
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Bus writes hold each channel until it is taken; a lost answer counts as an error.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    for (i = 0; i < 50 && !bvalid; i++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (i == 50) chk(1'b0, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] q);
    int i;
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    for (i = 0; i < 50 && !rvalid; i++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    {d, q} = {rdata, rresp};
    rready <= 1'b0;
    if (i == 50) chk(1'b0, 1'b1);
  endtask
  // New result; the model queues the word in the chosen channel order.
  task automatic newres(input logic a_first);
    @(posedge clk);
    result_a <= 16'($urandom);
    result_b <= 16'($urandom);
    result_valid <= 1'b1;
    @(posedge clk);
    result_valid <= 1'b0;
    exp_q.push_back(a_first ? {result_a, result_b} : {result_b, result_a});
  endtask
  // Bounded wait for busy to drop.
  task automatic idle;
    for (int k = 0; k < 80 && busy !== 1'b0; k++) @(posedge clk);
    chk(busy, 1'b0);
  endtask

  // Main sequence.
  initial begin
    {ce, rst_b, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
    {conv_busy, result_valid, awaddr, araddr, wdata, result_a, result_b} = '0;
    {wstrb, conv_eoc_n} = 5'h1F;
    w = $urandom(32'hDAEA);
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(serial_port_pkg::CTRL_OFFSET, w, r);
    chk(w, serial_port_pkg::CTRL_RESET);
    rd(8'h10, w, r);
    chk(r, 2'h2);
    for (int i = 0; i < 8; i++) begin
      host.sel(1'b0, 1'b0);
      wr(8'h00, 32'h80 | 32'(i % 2) << 4 | 32'(i / 2) << 5);
      newres(1'(i % 2));
      host.master_read(1'b0, w, per, s, b);
      chk(w, exp_q.pop_front());
      chk(per, 4 << (i / 2));
      chk({s, b}, 2'h1);
      idle();
    end
    wr(8'h00, 32'h9C);
    newres(1'b1);
    host.master_read(1'b1, w, per, s, b);
    chk({s, w}, {1'b0, exp_q.pop_front()});
    idle();
    wr(8'h00, 32'h90);
    host.sel(1'b0, 1'b1);
    repeat (3) @(posedge clk);
    newres(1'b1);
    conv_busy <= 1'b1;
    host.master_read(1'b0, w, per, s, b);
    conv_busy <= 1'b0;
    chk({s, w}, {1'b1, exp_q.pop_front()});
    idle();
    for (int i = 0; i < 2; i++) begin
      wr(8'h00, 32'h81 | 32'(i) << 4);
      host.sel(1'b1, 1'b1);
      newres(1'(i));
      host.slave_read(33, sw);
      chk(sw[32:0], {exp_q.pop_front(), 1'b1});
    end
    wr(8'h00, 32'h83);
    host.sel(1'b1, 1'b0);
    newres(1'b0);
    for (int j = 0; j < 2; j++) begin
      conv_busy <= 1'b1;
      host.slave_read(j ? 8 : 32, sw);
      @(posedge clk);
      conv_busy <= 1'b0;
      s = 1'b0;
      repeat (10) @(posedge clk) s |= late_read_error;
      chk({s, sw[7:0]}, {1'(j), j ? exp_q[0][31:24] : exp_q[0][7:0]});
    end
    rd(serial_port_pkg::RESA_OFFSET, w, r);
    chk(w[15:0], result_a);
    end_sim();
  end
endmodule
